/* hw/eth_flags_pkg.sv */
/*
 package of constants and carriers for the ethernet interrupt-request flags
 and the non-back-to-back inter-packet gap block.
 assumes one 40 MHz clock, synchronous active-high reset, AXI4-Lite software side.
*/
package eth_flags_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int GAP_W = 7;
   localparam int CNT_W = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFS_IRQ = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_TOGGLE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_GAP = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h18;

   // interrupt request bit positions
   localparam int BIT_OVFLW = 0;
   localparam int BIT_BUFNA = 1;
   localparam int BIT_TX_ABORT = 2;
   localparam int BIT_TX_DONE = 3;
   localparam int BIT_UNUSED = 4;
   localparam int BIT_RX_ACTIVITY = 5;
   localparam int BIT_PEND = 6;
   localparam logic [DATA_W-1:0] STICKY_MASK = 32'h0000_002F;

   // gap register layout and reset values
   localparam int GAP1_LSB = 8;
   localparam int GAP2_LSB = 0;
   localparam logic [GAP_W-1:0] GAP1_RST = 7'h0C;
   localparam logic [GAP_W-1:0] GAP2_RST = 7'h12;

   // control register
   localparam int BIT_DEC = 0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic rx_stored;
      logic tx_done;
      logic [4:0] tx_abort_why;
      logic rx_desc_overrun;
      logic rx_fifo_overflow;
   } mac_events_t;

   typedef struct packed {
      logic [GAP_W-1:0] part_one;
      logic [GAP_W-1:0] part_two;
   } gap_cfg_t;

   typedef enum logic [1:0] {
      GAP_IDLE,
      GAP_PART_ONE,
      GAP_PART_TWO
   } gap_state_t;
endpackage

/* hw/gap_timer.sv */
/*
 non-back-to-back inter-packet gap timer.
 assumes a carrier level already synchronised, one count per clock.
*/
`timescale 1ns/10ps
module gap_timer
   import eth_flags_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire gap_cfg_t i_cfg,
   input wire logic i_carrier,
   input wire logic i_tx_request,
   output logic o_tx_go,
   output logic o_deferring
);
   gap_state_t state_r;
   gap_state_t state_nxt;
   logic [GAP_W-1:0] count_r;
   logic [GAP_W-1:0] count_nxt;
   logic go_nxt;

   wire logic part_one_end = (count_r >= i_cfg.part_one);
   wire logic part_two_end = (count_r >= i_cfg.part_two);

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r + 7'h01;
      go_nxt = 1'b0;
      unique case (state_r)
         GAP_IDLE: begin
            count_nxt = '0;
            if (i_tx_request && !i_carrier) begin
               state_nxt = GAP_PART_ONE;
            end
         end
         GAP_PART_ONE: begin
            if (i_carrier || !i_tx_request) begin
               // carrier inside part one defers; a withdrawn request stops timing
               state_nxt = GAP_IDLE;
            end else if (part_one_end) begin
               state_nxt = GAP_PART_TWO;
            end
         end
         GAP_PART_TWO: begin
            // carrier no longer looked at
            if (!i_tx_request) begin
               state_nxt = GAP_IDLE;
            end else if (part_two_end) begin
               state_nxt = GAP_IDLE;
               go_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_r <= GAP_IDLE;
         count_r <= '0;
         o_tx_go <= 1'b0;
         o_deferring <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         o_tx_go <= go_nxt;
         o_deferring <= i_tx_request && i_carrier && (state_r != GAP_PART_TWO);
      end
   end
endmodule

/* hw/eth_flags.sv */
/*
 ethernet interrupt-request flags and inter-packet gap register with an
 AXI4-Lite slave. assumes mac events are one-cycle pulses on i_clk and the
 carrier sense pin is asynchronous.
*/
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module eth_flags
   import eth_flags_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic [2:0] i_awprot,
   input wire logic i_awvalid,
   output logic o_awready,
   // write data
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // read address
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic [2:0] i_arprot,
   input wire logic i_arvalid,
   output logic o_arready,
   // read data
   output logic [DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // mac and buffer manager side
   input wire mac_events_t i_events,
   input wire logic [CNT_W-1:0] i_rx_buffer_counter,
   output logic o_rx_counter_decrement,
   output logic o_packet_pending_flag,
   // gap timing
   input wire logic i_carrier_sense,
   input wire logic i_tx_request,
   output logic o_tx_go,
   output logic o_deferring
);
   // merge write data into an old value under the byte strobes
   function automatic logic [DATA_W-1:0] strobe_merge(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [3:0] strb);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // true for any mapped register address
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_IRQ) || (a == OFS_IRQ_CLR) || (a == OFS_IRQ_SET) ||
             (a == OFS_IRQ_TOGGLE) || (a == OFS_GAP) || (a == OFS_CTRL) ||
             (a == OFS_COUNT);
   endfunction

   // write channel state
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   // read channel state
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;

   // block state
   logic [DATA_W-1:0] sticky_r;
   logic [DATA_W-1:0] sticky_nxt;
   logic pending_r;
   logic dec_r;
   gap_cfg_t gap_r;
   gap_cfg_t gap_nxt;
   logic carrier_meta_r;
   logic carrier_sync_r;

   wire logic aw_fire = i_awvalid && awready_r;
   wire logic w_fire = i_wvalid && wready_r;
   wire logic ar_fire = i_arvalid && arready_r;
   wire logic wr_do = aw_held_r && w_held_r && !bvalid_r;
   // the counter is read-only, so a write to it is refused
   wire logic wr_ok = is_mapped(waddr_r) && (waddr_r != OFS_COUNT);

   // one decoded strobe per register write
   wire logic wr_irq = wr_do && (waddr_r == OFS_IRQ);
   wire logic wr_clr = wr_do && (waddr_r == OFS_IRQ_CLR);
   wire logic wr_set = wr_do && (waddr_r == OFS_IRQ_SET);
   wire logic wr_toggle = wr_do && (waddr_r == OFS_IRQ_TOGGLE);
   wire logic wr_gap = wr_do && (waddr_r == OFS_GAP);
   wire logic wr_ctrl = wr_do && (waddr_r == OFS_CTRL);

   wire logic [DATA_W-1:0] wr_val = strobe_merge('0, wdata_r, wstrb_r);
   // bits 31:15 and 7 of the gap word read zero
   wire logic [DATA_W-1:0] gap_word =
      {17'h0, gap_r.part_one, 1'b0, gap_r.part_two};
   wire logic [DATA_W-1:0] gap_word_nxt = strobe_merge(gap_word, wdata_r, wstrb_r);

   // any listed abort reason raises the abort event
   wire logic abort_ev = |i_events.tx_abort_why;

   // hardware events as a word at their bit positions
   wire logic [DATA_W-1:0] event_word =
      (DATA_W'(i_events.rx_stored) << BIT_RX_ACTIVITY) |
      (DATA_W'(i_events.tx_done) << BIT_TX_DONE) |
      (DATA_W'(abort_ev) << BIT_TX_ABORT) |
      (DATA_W'(i_events.rx_desc_overrun) << BIT_BUFNA) |
      (DATA_W'(i_events.rx_fifo_overflow) << BIT_OVFLW);

   // software view of the sticky flags before events
   logic [DATA_W-1:0] sticky_sw;
   always_comb begin
      sticky_sw = sticky_r;
      if (wr_irq) begin
         sticky_sw = strobe_merge(sticky_r, wdata_r, wstrb_r);
      end else if (wr_clr) begin
         sticky_sw = sticky_r & ~wr_val;
      end else if (wr_set) begin
         sticky_sw = sticky_r | wr_val;
      end else if (wr_toggle) begin
         sticky_sw = sticky_r ^ wr_val;
      end
   end

   // events win over a clear in the same cycle; bit four never stored
   assign sticky_nxt = (sticky_sw | event_word) & STICKY_MASK;

   always_comb begin
      gap_nxt = gap_r;
      if (wr_gap) begin
         gap_nxt.part_one = gap_word_nxt[GAP1_LSB +: GAP_W];
         gap_nxt.part_two = gap_word_nxt[GAP2_LSB +: GAP_W];
      end
   end

   // decrement request from the control register
   wire logic dec_nxt = wr_ctrl && wstrb_r[0] && wdata_r[BIT_DEC];

   // read mux
   wire logic [DATA_W-1:0] irq_word =
      sticky_r | (DATA_W'(pending_r) << BIT_PEND);
   logic [DATA_W-1:0] rd_val;
   always_comb begin
      rd_val = '0;
      unique case (i_araddr)
         OFS_IRQ, OFS_IRQ_CLR, OFS_IRQ_SET, OFS_IRQ_TOGGLE: begin
            rd_val = irq_word;
         end
         OFS_GAP: begin
            rd_val = gap_word;
         end
         OFS_COUNT: begin
            rd_val = DATA_W'(i_rx_buffer_counter);
         end
         // control bits are write-only strobes
         OFS_CTRL: begin
            rd_val = '0;
         end
         default: begin
            rd_val = '0;
         end
      endcase
   end

   // write address and data capture
   // a held address or data word blocks its channel until the response is taken
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         aw_held_r <= 1'b0;
         waddr_r <= '0;
         awready_r <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_held_r <= 1'b1;
            waddr_r <= {i_awaddr[ADDR_W-1:2], 2'b00};
         end else if (bvalid_r && i_bready) begin
            aw_held_r <= 1'b0;
         end
         awready_r <= !aw_held_r && !aw_fire;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
         wready_r <= 1'b0;
      end else begin
         if (w_fire) begin
            w_held_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
         end else if (bvalid_r && i_bready) begin
            w_held_r <= 1'b0;
         end
         wready_r <= !w_held_r && !w_fire;
      end
   end

   // write response
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && i_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read channel
   // arready stays low the cycle after a handshake: one read under way at a time
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && i_rready) begin
            rvalid_r <= 1'b0;
         end
         arready_r <= !rvalid_r && !ar_fire && !(arready_r && i_arvalid);
      end
   end

   // flag and configuration registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sticky_r <= '0;
         gap_r.part_one <= GAP1_RST;
         gap_r.part_two <= GAP2_RST;
         dec_r <= 1'b0;
      end else begin
         sticky_r <= sticky_nxt;
         gap_r <= gap_nxt;
         dec_r <= dec_nxt;
      end
   end

   // pending follows the counter; no write path reaches it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pending_r <= 1'b0;
      end else begin
         pending_r <= (i_rx_buffer_counter != '0);
      end
   end

   // carrier sense pin synchroniser
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         carrier_meta_r <= 1'b0;
         carrier_sync_r <= 1'b0;
      end else begin
         carrier_meta_r <= i_carrier_sense;
         carrier_sync_r <= carrier_meta_r;
      end
   end

   gap_timer u_gap_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_cfg(gap_r),
      .i_carrier(carrier_sync_r),
      .i_tx_request(i_tx_request),
      .o_tx_go(o_tx_go),
      .o_deferring(o_deferring)
   );

   // every output comes straight from its flip-flop
   assign o_awready = awready_r;
   assign o_wready = wready_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = arready_r;
   assign o_rvalid = rvalid_r;
   assign o_rdata = rdata_r;
   assign o_rresp = rresp_r;
   assign o_rx_counter_decrement = dec_r;
   assign o_packet_pending_flag = pending_r;
endmodule

/* dv/eth_flags_properties.sv */
/*
 concurrent checks on the eth_flags ports.
 assumes one clock i_clk and synchronous active-high i_reset.
*/
`timescale 1ns/10ps
module eth_flags_properties
   import eth_flags_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic [CNT_W-1:0] i_rx_buffer_counter,
   input wire logic o_rx_counter_decrement,
   input wire logic o_packet_pending_flag,
   input wire logic i_tx_request,
   input wire logic o_tx_go
);
   logic [ADDR_W-1:0] rd_addr_r;
   always_ff @(posedge i_clk) begin
      if (i_arvalid && o_arready) rd_addr_r <= i_araddr;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence aw_w_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence ar_take;
      i_arvalid && o_arready;
   endsequence
   pend_set_a: assert property (i_rx_buffer_counter != '0 |=> o_packet_pending_flag)
      else $error("pending flag low with packets waiting");
   pend_clear_a: assert property (i_rx_buffer_counter == '0 |=> !o_packet_pending_flag)
      else $error("pending flag high with empty counter");
   dec_pulse_a: assert property (o_rx_counter_decrement |=> !o_rx_counter_decrement)
      else $error("decrement longer than one cycle");
   irq_bit4_a: assert property (o_rvalid && rd_addr_r < OFS_GAP |-> !o_rdata[BIT_UNUSED])
      else $error("flag bit four read as one");
   gap_zero_a: assert property (o_rvalid && rd_addr_r == OFS_GAP |->
      o_rdata[31:15] == '0 && !o_rdata[7])
      else $error("gap register unused bits set");
   unmapped_rd_a: assert property (o_rvalid && rd_addr_r > OFS_COUNT |->
      o_rresp == RESP_SLVERR && o_rdata == '0)
      else $error("unmapped read not refused");
   wr_resp_a: assert property (aw_w_take |-> ##[1:2] o_bvalid)
      else $error("write response missing");
   rd_resp_a: assert property (ar_take |-> ##[1:2] o_rvalid)
      else $error("read data missing");
   go_pulse_a: assert property (o_tx_go |=> !o_tx_go)
      else $error("transmit go longer than one cycle");
   go_req_a: assert property (o_tx_go |-> $past(i_tx_request))
      else $error("transmit go without request");
endmodule
bind eth_flags eth_flags_properties chk (
   .i_clk, .i_reset, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
   .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
   .i_rx_buffer_counter, .o_rx_counter_decrement, .o_packet_pending_flag,
   .i_tx_request, .o_tx_go
);

/* dv/buffer_model.sv */
/*
 receive buffer counter of the buffer manager.
 assumes add and decrement are one-cycle pulses on i_clk.
*/
`timescale 1ns/10ps
module buffer_model
   import eth_flags_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_add,
   input wire logic i_dec,
   output logic [CNT_W-1:0] o_count
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   assign count_nxt = count_r + CNT_W'(i_add) - CNT_W'(i_dec && count_r != '0);
   always_ff @(posedge i_clk) begin
      if (i_reset) count_r <= '0;
      else count_r <= count_nxt;
   end
   assign o_count = count_r;
endmodule

/* dv/testbench.sv */
/*
 register-level testbench of eth_flags.
 assumes the buffer model as counter source and bench-driven mac events.
*/
`timescale 1ns/10ps
module testbench;
   import eth_flags_pkg::*;
   logic i_clk = 1'h0;
   logic i_reset = 1'h1;
   logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
   logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata;
   logic [3:0] i_wstrb = 4'hF;
   logic [1:0] o_bresp, o_rresp;
   logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   mac_events_t i_events = '0;
   logic [CNT_W-1:0] i_rx_buffer_counter;
   logic add = 1'h0, i_carrier_sense = 1'h0, i_tx_request = 1'h0;
   logic o_rx_counter_decrement, o_packet_pending_flag, o_tx_go, o_deferring;
   int bad_count = 0;
   int samples_checked = 0;
   logic [1:0] bresp_seen;
   int bits[9] = '{0, 1, 2, 2, 2, 2, 2, 3, 5};
   eth_flags dut (
      .i_clk, .i_reset, .i_awaddr, .i_awprot, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arprot,
      .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_events,
      .i_rx_buffer_counter, .o_rx_counter_decrement, .o_packet_pending_flag,
      .i_carrier_sense, .i_tx_request, .o_tx_go, .o_deferring
   );
   buffer_model model (.i_clk, .i_reset, .i_add(add), .i_dec(o_rx_counter_decrement),
      .o_count(i_rx_buffer_counter));
   always #12.5 i_clk = ~i_clk;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do begin
         @(posedge i_clk);
         n++;
         if (i_awvalid && o_awready) i_awvalid <= 1'h0;
         if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      end while (o_bvalid !== 1'h1 && n < 50);
      bresp_seen = o_bresp;
      i_bready <= 1'h0;
      if (n >= 50) bad_count++;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do begin
         @(posedge i_clk);
         n++;
         if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      end while (o_rvalid !== 1'h1 && n < 50);
      d = o_rdata;
      r = o_rresp;
      i_rready <= 1'h0;
      if (n >= 50) bad_count++;
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, exp);
   endtask
   task automatic pulse(input mac_events_t e);
      @(posedge i_clk);
      i_events <= e;
      @(posedge i_clk);
      i_events <= '0;
      repeat (2) @(posedge i_clk);
   endtask
   task automatic wait_go(input int lim, output logic seen);
      seen = 1'h0;
      for (int n = 0; n < lim && !seen; n++) begin
         @(posedge i_clk);
         if (o_tx_go === 1'h1) seen = 1'h1;
      end
   endtask
   function automatic mac_events_t ev_of(input int b, input int k);
      mac_events_t e;
      e = '0;
      case (b)
         0: e.rx_fifo_overflow = 1'h1;
         1: e.rx_desc_overrun = 1'h1;
         2: e.tx_abort_why[k] = 1'h1;
         3: e.tx_done = 1'h1;
         default: e.rx_stored = 1'h1;
      endcase
      return e;
   endfunction
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      end_sim();
   end
   initial begin
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      logic s;
      repeat (5) @(posedge i_clk);
      i_reset <= 1'h0;
      repeat (2) @(posedge i_clk);
      rchk(OFS_IRQ, 32'h0000_0000);
      rchk(OFS_GAP, 32'h0000_0C12);
      wr(OFS_GAP, 32'hFFFF_FFFF);
      rchk(OFS_GAP, 32'h0000_7F7F);
      check({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
      wr(OFS_COUNT, 32'h0000_0001);
      check({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
      rchk(OFS_COUNT, 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
         pulse(ev_of(bits[i], i - 2));
         rchk(OFS_IRQ, 32'h1 << bits[i]);
         wr(OFS_IRQ_CLR, ~(32'h1 << bits[i]));
         rchk(OFS_IRQ, 32'h1 << bits[i]);
         wr(OFS_IRQ_CLR, 32'h1 << bits[i]);
         rchk(OFS_IRQ, 32'h0000_0000);
      end
      @(posedge i_clk);
      add <= 1'h1;
      @(posedge i_clk);
      add <= 1'h0;
      repeat (3) @(posedge i_clk);
      check({31'h0, o_packet_pending_flag}, 32'h1);
      wr(OFS_IRQ, 32'h0000_0000);
      wr(OFS_IRQ_CLR, 32'h0000_0040);
      rchk(OFS_IRQ, 32'h0000_0040);
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (3) @(posedge i_clk);
      check({31'h0, o_packet_pending_flag}, 32'h0);
      wr(OFS_IRQ_SET, 32'h0000_0010);
      rchk(OFS_IRQ, 32'h0000_0000);
      wr(OFS_IRQ_SET, 32'h0000_0020);
      rchk(OFS_IRQ, 32'h0000_0020);
      wr(OFS_IRQ_TOGGLE, 32'h0000_0020);
      rchk(OFS_IRQ, 32'h0000_0000);
      rd(8'h20, d, r);
      check(d, 32'h0000_0000);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(OFS_GAP, 32'h0000_0C12);
      i_tx_request <= 1'h1;
      wait_go(100, s);
      check({31'h0, s}, 32'h1);
      i_tx_request <= 1'h0;
      i_carrier_sense <= 1'h1;
      repeat (4) @(posedge i_clk);
      i_tx_request <= 1'h1;
      wait_go(60, s);
      check({31'h0, s}, 32'h0);
      check({31'h0, o_deferring}, 32'h1);
      i_carrier_sense <= 1'h0;
      wait_go(100, s);
      check({31'h0, s}, 32'h1);
      i_tx_request <= 1'h0;
      repeat (5) @(posedge i_clk);
      i_tx_request <= 1'h1;
      repeat (14) @(posedge i_clk);
      i_carrier_sense <= 1'h1;
      wait_go(60, s);
      check({31'h0, s}, 32'h1);
      i_tx_request <= 1'h0;
      i_carrier_sense <= 1'h0;
      repeat (4) @(posedge i_clk);
      end_sim();
   end
endmodule
